// ===== common/vter_map.vh
`ifndef VTER_MAP_VH
`define VTER_MAP_VH

// privilege encodings
`define VTER_PRIV_U        2'h0
`define VTER_PRIV_S        2'h1
`define VTER_PRIV_M        2'h3

// exception codes
`define VTER_EC_ILLEGAL    4'h2
`define VTER_EC_ENV_CALL_OP_U    4'h8
`define VTER_EC_ENV_CALL_OP_HS   4'h9
`define VTER_EC_ENV_CALL_OP_VS   4'ha
`define VTER_EC_ENV_CALL_OP_M    4'hb
`define VTER_EC_RSVD       4'he

// interrupt kinds, code = kind * 4 + level
`define VTER_IK_SOFT       2'h0
`define VTER_IK_TIMER      2'h1
`define VTER_IK_EXT        2'h2

// cause register layout
`define VTER_CAUSE_IRQ_BIT 31
`define VTER_CODE_W        4

// register byte addresses
`define VTER_A_MSTAT       8'h00
`define VTER_A_SSTAT       8'h04
`define VTER_A_HSTAT       8'h08
`define VTER_A_MCAUSE      8'h0c
`define VTER_A_SCAUSE      8'h10
`define VTER_A_MEPC        8'h14
`define VTER_A_SEPC        8'h18
`define VTER_A_MTVEC       8'h1c
`define VTER_A_STVEC       8'h20
`define VTER_A_MEDEL       8'h24
`define VTER_A_MIDEL       8'h28
`define VTER_A_HEDEL       8'h2c
`define VTER_A_HIDEL       8'h30
`define VTER_A_SEDEL       8'h34
`define VTER_A_SIDEL       8'h38
`define VTER_A_MODE        8'h3c
`define VTER_A_ISTAT       8'h40
`define VTER_A_IMASK       8'h44
`define VTER_A_UCAUSE      8'h48
`define VTER_A_UEPC        8'h4c
`define VTER_A_UTVEC       8'h50

// machine status field positions
`define VTER_MS_IE         0
`define VTER_MS_PIE        1
`define VTER_MS_PP_LO      2
`define VTER_MS_PV         4
// supervisor status field positions
`define VTER_SS_IE         0
`define VTER_SS_PIE        1
`define VTER_SS_PP         2
// hypervisor status field positions
`define VTER_HS_PV         0
`define VTER_HS_P2V        1
`define VTER_HS_P2P        2

// event status bits
`define VTER_EV_W          5
`define VTER_EV_TRAP_M     0
`define VTER_EV_TRAP_HS    1
`define VTER_EV_TRAP_LOW   2
`define VTER_EV_WFI_TO     3
`define VTER_EV_RET        4

// timing
`define VTER_CLK_PERIOD_NS 8
`define VTER_WFI_LIMIT_NS  1000

`endif

// ===== hw/vter_ctrl.v
// Behaviour
// - wait_interrupt_op in virtual modes unfinished within bounded time raises illegal instruction.
// - env_call_op from hypervisor_supervisor reports cause 9, from virtual_supervisor 10.
// - traps from hypervisor_supervisor or user go to machine unless machine-delegated.
// - with user interrupts, delegated user traps headed to supervisor go to user.
// - virtual traps go machine, hypervisor_supervisor, or virtual_supervisor by delegation chain.
// - with user interrupts, delegated virtual_user traps go to virtual_user.
// - interrupt codes: software 0/1/3, timer 4/5/7, external 8/9/11.
// - exception codes fixed; env_call_op user 8, machine 11; page faults 12,13,15.
// - machine trap from virtual state swaps supervisor sets before recording prior state.
// - machine trap records prior virt/priv per previous mode.
// - supervisor trap swaps if virtual, shifts prior into second-prior, then updates.
// - supervisor trap records prior virt/priv per previous mode.
// - virtual_supervisor trap sets prior priv only, hypervisor bits kept, virt stays.
// - machine return restores mode, clears prior, moves enables, jumps, swaps if virtual.
// - machine return ignores prior virt when prior priv is machine.
// - unvirtualized supervisor return restores mode, swaps last if new virt is one.
// - it also shifts second-prior into prior, clears second-prior, moves enables, jumps.
// - virtualized supervisor return picks mode from prior priv, clears it, jumps.
`timescale 1ns/1ps
`include "vter_map.vh"
module vter_ctrl #(
  parameter       USER_IRQ_EN  = 1,
  parameter       WFI_LIMIT_NS = `VTER_WFI_LIMIT_NS
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        trapReq,
  input  wire        trapIrq,
  input  wire [3:0]  trapCode,
  input  wire [1:0]  irqKind,
  input  wire [1:0]  irqLevel,
  input  wire        envCallReq,
  input  wire [31:0] trapPc,
  input  wire        mretReq,
  input  wire        sretReq,
  input  wire        wfiReq,
  input  wire        wfiWake,
  output reg         wfiDone,
  output wire        wfiBusy,
  output reg         redirValid,
  output reg  [31:0] redirPc,
  output reg         swapPulse,
  output wire [1:0]  curPriv,
  output wire        curVirt,
  output wire        irq
);

  localparam integer WFI_RAW = WFI_LIMIT_NS / `VTER_CLK_PERIOD_NS;
  localparam integer WFI_CYC = (WFI_RAW < 1) ? 1 : WFI_RAW;
  localparam integer WFI_LASTI = WFI_CYC - 1;
  localparam [15:0]  WFI_LAST = WFI_LASTI[15:0];

  reg [1:0]  priv_q;
  reg        virt_q;
  reg        mie_q, mach_prior_intr_enable_q, mpv_q;
  reg [1:0]  mpp_q;
  reg        sie_q, sup_prior_intr_enable_q, spp_q;
  reg        bgSie_q, bgSpie_q, bgSpp_q;
  reg        spv_q, sup_second_prior_virt_q, sup_second_prior_priv_q;
  reg [31:0] mcause_q, scause_q, bgScause_q, ucause_q;
  reg [31:0] mepc_q, sepc_q, bgSepc_q, uepc_q;
  reg [31:0] mtvec_q, stvec_q, bgStvec_q, utvec_q;
  reg [15:0] medel_q, midel_q, hedel_q, hidel_q, sedel_q, sidel_q;
  reg [`VTER_EV_W-1:0] evStat_q, evMask_q;
  reg        wfiBusy_q;
  reg [15:0] wfiCnt_q;

  assign curPriv = priv_q;
  assign curVirt = virt_q;
  assign wfiBusy = wfiBusy_q;
  assign irq     = |(evStat_q & evMask_q);
  assign pready  = 1'b1;

  // wait timeout only applies while virtualized
  wire wfiTo = wfiBusy_q & virt_q & ~wfiWake & (wfiCnt_q >= WFI_LAST);

  wire takeTrap = wfiTo | trapReq | envCallReq;
  wire isIrq    = ~wfiTo & ~envCallReq & trapIrq;
  wire doMret   = ~takeTrap & mretReq;
  wire doSret   = ~takeTrap & ~mretReq & sretReq;

  reg [3:0] ecallCode;
  always @* begin
    case ({virt_q, priv_q})
      {1'b0, `VTER_PRIV_S}: ecallCode = `VTER_EC_ENV_CALL_OP_HS;
      {1'b1, `VTER_PRIV_S}: ecallCode = `VTER_EC_ENV_CALL_OP_VS;
      {1'b0, `VTER_PRIV_M}: ecallCode = `VTER_EC_ENV_CALL_OP_M;
      default:              ecallCode = `VTER_EC_ENV_CALL_OP_U;
    endcase
  end

  wire [3:0] code = wfiTo      ? `VTER_EC_ILLEGAL :
                    envCallReq ? ecallCode :
                    trapIrq    ? {irqKind, irqLevel} :
                                 trapCode;
  wire [31:0] causeVal = {isIrq, 27'h0, code};

  wire mDel = isIrq ? midel_q[code] : medel_q[code];
  wire hDel = isIrq ? hidel_q[code] : hedel_q[code];
  wire sDel = (USER_IRQ_EN != 0) & (priv_q == `VTER_PRIV_U) &
              (isIrq ? sidel_q[code] : sedel_q[code]);

  reg [1:0] tgtPriv;
  reg       tgtVirt;
  always @* begin
    tgtPriv = `VTER_PRIV_M;
    tgtVirt = 1'b0;
    if (priv_q == `VTER_PRIV_M || !mDel) begin
      tgtPriv = `VTER_PRIV_M;
    end else if (!virt_q) begin
      tgtPriv = sDel ? `VTER_PRIV_U : `VTER_PRIV_S;
    end else if (!hDel) begin
      tgtPriv = `VTER_PRIV_S;
    end else begin
      tgtVirt = 1'b1;
      tgtPriv = sDel ? `VTER_PRIV_U : `VTER_PRIV_S;
    end
  end

  // supervisor state as seen after a swap taken from a virtual mode
  wire effSie  = virt_q ? bgSie_q  : sie_q;
  wire effSpp  = virt_q ? bgSpp_q  : spp_q;
  wire [31:0] effStvec = virt_q ? bgStvec_q : stvec_q;

  // machine return target
  wire       mretM    = (mpp_q == `VTER_PRIV_M);
  wire       mretVirt = mretM ? 1'b0 : mpv_q;
  // sets trade places when a trap leaves or a return enters virtual modes
  wire setSwap = takeTrap ? (virt_q & ~tgtVirt) :
                 doMret   ? mretVirt :
                 (doSret & ~virt_q & spv_q);

  // register file
  wire wrEn = psel & penable & pwrite;
  reg        hit;
  reg [31:0] rdVal;
  always @* begin
    hit   = 1'b1;
    rdVal = 32'h0;
    case (paddr)
      `VTER_A_MSTAT:  rdVal = {27'h0, mpv_q, mpp_q, mach_prior_intr_enable_q, mie_q};
      `VTER_A_SSTAT:  rdVal = {29'h0, spp_q, sup_prior_intr_enable_q, sie_q};
      `VTER_A_HSTAT:  rdVal = {29'h0, sup_second_prior_priv_q, sup_second_prior_virt_q, spv_q};
      `VTER_A_MCAUSE: rdVal = mcause_q;
      `VTER_A_SCAUSE: rdVal = scause_q;
      `VTER_A_MEPC:   rdVal = mepc_q;
      `VTER_A_SEPC:   rdVal = sepc_q;
      `VTER_A_MTVEC:  rdVal = mtvec_q;
      `VTER_A_STVEC:  rdVal = stvec_q;
      `VTER_A_MEDEL:  rdVal = {16'h0, medel_q};
      `VTER_A_MIDEL:  rdVal = {16'h0, midel_q};
      `VTER_A_HEDEL:  rdVal = {16'h0, hedel_q};
      `VTER_A_HIDEL:  rdVal = {16'h0, hidel_q};
      `VTER_A_SEDEL:  rdVal = {16'h0, sedel_q};
      `VTER_A_SIDEL:  rdVal = {16'h0, sidel_q};
      `VTER_A_MODE:   rdVal = {28'h0, wfiBusy_q, virt_q, priv_q};
      `VTER_A_ISTAT:  rdVal = {27'h0, evStat_q};
      `VTER_A_IMASK:  rdVal = {27'h0, evMask_q};
      `VTER_A_UCAUSE: rdVal = ucause_q;
      `VTER_A_UEPC:   rdVal = uepc_q;
      `VTER_A_UTVEC:  rdVal = utvec_q;
      default:        hit   = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~hit;

  // read data captured in the setup phase
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0;
    end else if (psel & ~penable) begin
      prdata <= rdVal;
    end
  end

  reg [`VTER_EV_W-1:0] evSet;
  always @* begin
    evSet = {`VTER_EV_W{1'b0}};
    if (takeTrap) begin
      if (tgtPriv == `VTER_PRIV_M)
        evSet[`VTER_EV_TRAP_M] = 1'b1;
      else if (tgtPriv == `VTER_PRIV_S && !tgtVirt)
        evSet[`VTER_EV_TRAP_HS] = 1'b1;
      else
        evSet[`VTER_EV_TRAP_LOW] = 1'b1;
    end
    evSet[`VTER_EV_WFI_TO] = wfiTo;
    evSet[`VTER_EV_RET]    = doMret | doSret;
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      priv_q     <= `VTER_PRIV_M;
      virt_q     <= 1'b0;
      mie_q      <= 1'b0;
      mach_prior_intr_enable_q     <= 1'b0;
      mpv_q      <= 1'b0;
      mpp_q      <= `VTER_PRIV_U;
      sie_q      <= 1'b0;
      sup_prior_intr_enable_q     <= 1'b0;
      spp_q      <= 1'b0;
      bgSie_q    <= 1'b0;
      bgSpie_q   <= 1'b0;
      bgSpp_q    <= 1'b0;
      spv_q      <= 1'b0;
      sup_second_prior_virt_q     <= 1'b0;
      sup_second_prior_priv_q     <= 1'b0;
      mcause_q   <= 32'h0;
      scause_q   <= 32'h0;
      bgScause_q <= 32'h0;
      ucause_q   <= 32'h0;
      mepc_q     <= 32'h0;
      sepc_q     <= 32'h0;
      bgSepc_q   <= 32'h0;
      uepc_q     <= 32'h0;
      mtvec_q    <= 32'h0;
      stvec_q    <= 32'h0;
      bgStvec_q  <= 32'h0;
      utvec_q    <= 32'h0;
      medel_q    <= 16'h0;
      midel_q    <= 16'h0;
      hedel_q    <= 16'h0;
      hidel_q    <= 16'h0;
      sedel_q    <= 16'h0;
      sidel_q    <= 16'h0;
      evStat_q   <= {`VTER_EV_W{1'b0}};
      evMask_q   <= {`VTER_EV_W{1'b0}};
      wfiBusy_q  <= 1'b0;
      wfiCnt_q   <= 16'h0;
      wfiDone    <= 1'b0;
      redirValid <= 1'b0;
      redirPc    <= 32'h0;
      swapPulse  <= 1'b0;
    end else begin
      redirValid <= 1'b0;
      swapPulse  <= 1'b0;
      wfiDone    <= 1'b0;
      // software writes first; hardware updates below take priority
      if (wrEn) begin
        case (paddr)
          `VTER_A_MSTAT: begin
            mie_q  <= pwdata[`VTER_MS_IE];
            mach_prior_intr_enable_q <= pwdata[`VTER_MS_PIE];
            mpp_q  <= (pwdata[`VTER_MS_PP_LO+1 -: 2] == 2'h2) ?
                      `VTER_PRIV_U : pwdata[`VTER_MS_PP_LO+1 -: 2];
            mpv_q  <= pwdata[`VTER_MS_PV];
          end
          `VTER_A_SSTAT: begin
            sie_q  <= pwdata[`VTER_SS_IE];
            sup_prior_intr_enable_q <= pwdata[`VTER_SS_PIE];
            spp_q  <= pwdata[`VTER_SS_PP];
          end
          `VTER_A_HSTAT: begin
            spv_q  <= pwdata[`VTER_HS_PV];
            sup_second_prior_virt_q <= pwdata[`VTER_HS_P2V];
            sup_second_prior_priv_q <= pwdata[`VTER_HS_P2P];
          end
          `VTER_A_MCAUSE: mcause_q <= pwdata;
          `VTER_A_SCAUSE: scause_q <= pwdata;
          `VTER_A_MEPC:   mepc_q   <= pwdata;
          `VTER_A_SEPC:   sepc_q   <= pwdata;
          `VTER_A_MTVEC:  mtvec_q  <= pwdata;
          `VTER_A_STVEC:  stvec_q  <= pwdata;
          `VTER_A_MEDEL:  medel_q  <= pwdata[15:0];
          `VTER_A_MIDEL:  midel_q  <= pwdata[15:0];
          `VTER_A_HEDEL:  hedel_q  <= pwdata[15:0];
          `VTER_A_HIDEL:  hidel_q  <= pwdata[15:0];
          `VTER_A_SEDEL:  sedel_q  <= pwdata[15:0];
          `VTER_A_SIDEL:  sidel_q  <= pwdata[15:0];
          `VTER_A_IMASK:  evMask_q <= pwdata[`VTER_EV_W-1:0];
          `VTER_A_UCAUSE: ucause_q <= pwdata;
          `VTER_A_UEPC:   uepc_q   <= pwdata;
          `VTER_A_UTVEC:  utvec_q  <= pwdata;
          default: ;
        endcase
      end
      // sticky events: a set in the clearing cycle wins
      if (wrEn && paddr == `VTER_A_ISTAT)
        evStat_q <= (evStat_q & ~pwdata[`VTER_EV_W-1:0]) | evSet;
      else
        evStat_q <= evStat_q | evSet;

      // wait for interrupt
      if (takeTrap) begin
        wfiBusy_q <= 1'b0;
      end else if (wfiBusy_q) begin
        if (wfiWake) begin
          wfiBusy_q <= 1'b0;
          wfiDone   <= 1'b1;
        end else if (virt_q) begin
          wfiCnt_q <= wfiCnt_q + 16'h1;
        end
      end else if (wfiReq) begin
        if (wfiWake) begin
          wfiDone <= 1'b1;
        end else begin
          wfiBusy_q <= 1'b1;
          wfiCnt_q  <= 16'h0;
        end
      end

      // plain exchange; the branches below override the fields they set
      if (setSwap) begin
        swapPulse  <= 1'b1;
        sie_q      <= bgSie_q;
        sup_prior_intr_enable_q     <= bgSpie_q;
        spp_q      <= bgSpp_q;
        scause_q   <= bgScause_q;
        sepc_q     <= bgSepc_q;
        stvec_q    <= bgStvec_q;
        bgSie_q    <= sie_q;
        bgSpie_q   <= sup_prior_intr_enable_q;
        bgSpp_q    <= spp_q;
        bgScause_q <= scause_q;
        bgSepc_q   <= sepc_q;
        bgStvec_q  <= stvec_q;
      end
      if (takeTrap) begin
        redirValid <= 1'b1;
        priv_q     <= tgtPriv;
        virt_q     <= tgtVirt;
        if (tgtPriv == `VTER_PRIV_M) begin
          mpv_q    <= virt_q;
          mpp_q    <= priv_q;
          mach_prior_intr_enable_q   <= mie_q;
          mie_q    <= 1'b0;
          mcause_q <= causeVal;
          mepc_q   <= trapPc;
          redirPc  <= mtvec_q;
        end else if (tgtPriv == `VTER_PRIV_S && !tgtVirt) begin
          sup_second_prior_virt_q   <= spv_q;
          sup_second_prior_priv_q   <= effSpp;
          spv_q    <= virt_q;
          spp_q    <= priv_q[0];
          sup_prior_intr_enable_q   <= effSie;
          sie_q    <= 1'b0;
          scause_q <= causeVal;
          sepc_q   <= trapPc;
          redirPc  <= effStvec;
        end else if (tgtPriv == `VTER_PRIV_S) begin
          spp_q    <= priv_q[0];
          sup_prior_intr_enable_q   <= sie_q;
          sie_q    <= 1'b0;
          scause_q <= causeVal;
          sepc_q   <= trapPc;
          redirPc  <= stvec_q;
        end else begin
          ucause_q <= causeVal;
          uepc_q   <= trapPc;
          redirPc  <= utvec_q;
        end
      end else if (doMret) begin
        redirValid <= 1'b1;
        priv_q     <= mpp_q;
        virt_q     <= mretVirt;
        mpv_q      <= 1'b0;
        mpp_q      <= `VTER_PRIV_U;
        mie_q      <= mach_prior_intr_enable_q;
        mach_prior_intr_enable_q     <= 1'b1;
        redirPc    <= mepc_q;
      end else if (doSret && !virt_q) begin
        redirValid <= 1'b1;
        priv_q     <= {1'b0, spp_q};
        virt_q     <= spv_q;
        spv_q      <= sup_second_prior_virt_q;
        sup_second_prior_virt_q     <= 1'b0;
        sup_second_prior_priv_q     <= 1'b0;
        redirPc    <= sepc_q;
        if (spv_q) begin
          bgSpp_q  <= sup_second_prior_priv_q;
          bgSie_q  <= sup_prior_intr_enable_q;
          bgSpie_q <= 1'b1;
        end else begin
          spp_q  <= sup_second_prior_priv_q;
          sie_q  <= sup_prior_intr_enable_q;
          sup_prior_intr_enable_q <= 1'b1;
        end
      end else if (doSret) begin
        redirValid <= 1'b1;
        priv_q     <= {1'b0, spp_q};
        spp_q      <= 1'b0;
        sie_q      <= sup_prior_intr_enable_q;
        sup_prior_intr_enable_q     <= 1'b1;
        redirPc    <= sepc_q;
      end
    end
  end

endmodule

// ===== test/vter_ctrl_monitor.sv
`timescale 1ns/1ps
`include "vter_map.vh"
module vter_ctrl_monitor #(
  parameter WFI_LIMIT_NS = `VTER_WFI_LIMIT_NS,
  parameter USER_IRQ_EN  = 1
) (
  input wire       ref_clk,
  input wire       rst_n,
  input wire       psel,
  input wire       penable,
  input wire       pslverr,
  input wire       trapReq,
  input wire       envCallReq,
  input wire       mretReq,
  input wire       sretReq,
  input wire       wfiWake,
  input wire       wfiDone,
  input wire       wfiBusy,
  input wire       redirValid,
  input wire       swapPulse,
  input wire [1:0] curPriv,
  input wire       curVirt
);
  localparam int WFI_MAX = WFI_LIMIT_NS / `VTER_CLK_PERIOD_NS + 2;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // traps and returns still act during a wait in progress; leave those out
  wire anyTrap = (trapReq || envCallReq) && !wfiBusy;
  wire anyRet  = (mretReq || sretReq) && !anyTrap && !wfiBusy;
  sequence s_virtTrap;  anyTrap && curVirt;  endsequence
  sequence s_plainTrap; anyTrap && !curVirt; endsequence
  sequence s_plainRet;  anyRet && !curVirt;  endsequence
  property p_machNoVirt; curPriv == 2'h3 |-> !curVirt; endproperty
  a_machNoVirt: assert property (p_machNoVirt)
    else $error("machine mode shown virtualized");
  property p_virtTrapSwap; s_virtTrap ##1 !curVirt |-> swapPulse; endproperty
  a_virtTrapSwap: assert property (p_virtTrapSwap)
    else $error("no set swap on trap out of virtual mode");
  property p_virtTrapStay; s_virtTrap ##1 curVirt |-> !swapPulse; endproperty
  a_virtTrapStay: assert property (p_virtTrapStay)
    else $error("set swap on trap staying virtual");
  property p_virtTrapDest;
    s_virtTrap |=> curVirt || curPriv != 2'h0;
  endproperty
  a_virtTrapDest: assert property (p_virtTrapDest)
    else $error("virtual trap landed in plain user mode");
  property p_plainTrap; s_plainTrap |=> !curVirt && !swapPulse; endproperty
  a_plainTrap: assert property (p_plainTrap)
    else $error("plain trap entered virtual mode or swapped");
  property p_retSwap; s_plainRet |=> swapPulse == curVirt; endproperty
  a_retSwap: assert property (p_retSwap)
    else $error("return swap does not match new virtual mode");
  property p_vsRet;
    sretReq && !mretReq && anyRet && curVirt |=>
      curVirt && !swapPulse && !curPriv[1];
  endproperty
  a_vsRet: assert property (p_vsRet)
    else $error("virtual supervisor return left virtual modes");
  property p_wfiBound; $rose(wfiBusy) && curVirt |-> ##[1:WFI_MAX] !wfiBusy;
  endproperty
  a_wfiBound: assert property (p_wfiBound)
    else $error("virtual wait not bounded");
  property p_wfiTrap;
    wfiBusy && curVirt && !wfiWake && !trapReq && !envCallReq ##1 !wfiBusy
      |-> redirValid;
  endproperty
  a_wfiTrap: assert property (p_wfiTrap)
    else $error("wait ended without trap");
  property p_wfiWake;
    wfiBusy && wfiWake && !trapReq && !envCallReq |=> wfiDone && !wfiBusy;
  endproperty
  a_wfiWake: assert property (p_wfiWake)
    else $error("wake did not finish the wait");
  property p_slverr; pslverr |-> psel && penable; endproperty
  a_slverr: assert property (p_slverr)
    else $error("bus error outside access phase");
endmodule

bind vter_ctrl vter_ctrl_monitor #(
  .WFI_LIMIT_NS(WFI_LIMIT_NS),
  .USER_IRQ_EN (USER_IRQ_EN)
) i_vter_ctrl_monitor (
  .ref_clk, .rst_n, .psel, .penable, .pslverr, .trapReq, .envCallReq,
  .mretReq, .sretReq, .wfiWake, .wfiDone, .wfiBusy, .redirValid,
  .swapPulse, .curPriv, .curVirt
);

// ===== test/vter_pipe_model.sv
`timescale 1ns/1ps
module vter_pipe_model (
  input  wire         ref_clk,
  output logic        trapReq,
  output logic        trapIrq,
  output logic [3:0]  trapCode,
  output logic [1:0]  irqKind,
  output logic [1:0]  irqLevel,
  output logic        envCallReq,
  output logic [31:0] trapPc,
  output logic        mretReq,
  output logic        sretReq,
  output logic        wfiReq,
  output logic        wfiWake
);
  initial begin
    {trapReq, trapIrq, trapCode, irqKind, irqLevel} = 9'h0;
    {envCallReq, mretReq, sretReq, wfiReq, wfiWake} = 5'h0;
    trapPc = 32'hffff_bfff;
  end
  // op: 0 exception, 1 interrupt, 2 env call, 3 machine_trap_return_op, 4 supervisor_trap_return_op, 5 wait
  task automatic issue(input logic [2:0] op, input logic [3:0] code);
    @(posedge ref_clk);
    trapReq <= op < 3'h2;
    trapIrq <= op == 3'h1;
    trapCode <= code;
    {irqKind, irqLevel} <= code;
    envCallReq <= op == 3'h2;
    mretReq <= op == 3'h3;
    sretReq <= op == 3'h4;
    wfiReq <= op == 3'h5;
    trapPc <= 32'h0000_4000;
    @(posedge ref_clk);
    {trapReq, envCallReq, mretReq, sretReq, wfiReq} <= 5'h0;
    // qualifiers no longer hold their value once the request is gone
    trapCode <= ~code;
    {irqKind, irqLevel} <= ~code;
    trapPc <= 32'hffff_bfff;
  endtask
  task automatic setWake(input logic v);
    @(posedge ref_clk);
    wfiWake <= v;
  endtask
endmodule

// ===== test/vter_ctrl_tb.sv
`timescale 1ns/1ps
`include "vter_map.vh"
module vter_ctrl_tb;
  typedef struct packed {
    logic [7:0]  mst;
    logic [15:0] del;
    logic [15:0] hdel;
    logic [2:0]  op;
    logic [3:0]  code;
    logic [1:0]  priv;
    logic        virt;
    logic [7:0]  addr;
    logic [31:0] exp;
  } vter_row_t;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  wire  [31:0] prdata, trapPc, redirPc;
  wire  [3:0]  trapCode;
  wire  [1:0]  irqKind, irqLevel, curPriv;
  wire         pready, pslverr, trapReq, trapIrq, envCallReq, mretReq;
  wire         sretReq, wfiReq, wfiWake, wfiDone, wfiBusy, redirValid;
  wire         swapPulse, curVirt, irq;
  int          failures = 0;
  int          nTests = 0;
  vter_row_t   rows [13];
  vter_row_t   r;
  logic [31:0] q;
  logic        err;

  always #4 ref_clk = ~ref_clk;

  vter_ctrl #(.WFI_LIMIT_NS(40)) i_vter_ctrl (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .trapReq, .trapIrq, .trapCode, .irqKind, .irqLevel,
    .envCallReq, .trapPc, .mretReq, .sretReq, .wfiReq, .wfiWake, .wfiDone,
    .wfiBusy, .redirValid, .redirPc, .swapPulse, .curPriv, .curVirt, .irq
  );
  vter_pipe_model i_vter_pipe_model (
    .ref_clk, .trapReq, .trapIrq, .trapCode, .irqKind, .irqLevel,
    .envCallReq, .trapPc, .mretReq, .sretReq, .wfiReq, .wfiWake
  );

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      print_verdict();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic [2:0] o, input logic [3:0] c);
    i_vter_pipe_model.issue(o, c);
    // results settle one edge after the request is taken
    @(posedge ref_clk);
  endtask
  task automatic waitFor(input logic done);
    int n;
    n = 0;
    while ((done ? wfiDone : redirValid) !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 200) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic resetDut;
    rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask

  initial begin
    // mode via machine_trap_return_op, delegation masks, operation, expected mode and word
    rows[0]  = {8'h04,16'h0,16'h0,3'h2,4'h0,2'h3,1'h0,8'h0c,32'h9};
    rows[1]  = {8'h14,16'h0,16'h0,3'h2,4'h0,2'h3,1'h0,8'h0c,32'ha};
    rows[2]  = {8'h14,16'h0400,16'h0,3'h2,4'h0,2'h1,1'h0,8'h10,32'ha};
    rows[3]  = {8'h14,16'h0400,16'h0400,3'h2,4'h0,2'h1,1'h1,8'h10,32'ha};
    rows[4]  = {8'h10,16'h0,16'h0,3'h2,4'h0,2'h3,1'h0,8'h0c,32'h8};
    rows[5]  = {8'h00,16'h0004,16'h0,3'h0,4'h2,2'h1,1'h0,8'h10,32'h2};
    rows[6]  = {8'h10,16'h2000,16'h0,3'h0,4'hd,2'h1,1'h0,8'h08,32'h1};
    rows[7]  = {8'h14,16'h0,16'h0,3'h0,4'hc,2'h3,1'h0,8'h00,32'h14};
    rows[8]  = {8'h04,16'h0,16'h0,3'h1,4'h7,2'h3,1'h0,8'h0c,32'h80000007};
    rows[9]  = {8'h00,16'h0200,16'h0,3'h1,4'h9,2'h1,1'h0,8'h10,32'h80000009};
    rows[10] = {8'h00,16'h0001,16'h0001,3'h1,4'h0,2'h0,1'h0,8'h48,32'h80000000};
    rows[11] = {8'h10,16'h0100,16'h0100,3'h2,4'h0,2'h0,1'h1,8'h48,32'h8};
    rows[12] = {8'h14,16'h0008,16'h0008,3'h0,4'h3,2'h1,1'h1,8'h04,32'h4};
    for (int i = 0; i < 13; i++) begin
      r = rows[i];
      resetDut();
      for (int k = 0; k < 6; k++)
        apb(1'b1, 8'h24 + 8'(4 * k), (k < 2) ? 32'(r.del) : 32'(r.hdel));
      apb(1'b1, `VTER_A_MSTAT, 32'(r.mst));
      op(3'h3, 4'h0);
      op(r.op, r.code);
      apb(1'b0, r.addr, 32'h0);
      chk(q, r.exp);
      chk(32'({curVirt, curPriv}), 32'({r.virt, r.priv}));
      $display("row %0d done", i);
    end
    resetDut();
    apb(1'b0, `VTER_A_MODE, 32'h0);
    chk(q, 32'h3);
    chk(32'({irq, curVirt, curPriv}), 32'h3);
    $display("reset test done");
    apb(1'b1, `VTER_A_MEPC, 32'h1234);
    apb(1'b1, `VTER_A_MSTAT, 32'h1e);
    op(3'h3, 4'h0);
    chk(32'({curVirt, curPriv}), 32'h3);
    chk(redirPc, 32'h1234);
    apb(1'b0, `VTER_A_MSTAT, 32'h0);
    chk(q, 32'h3);
    apb(1'b1, `VTER_A_HSTAT, 32'h5);
    apb(1'b1, `VTER_A_SSTAT, 32'h6);
    apb(1'b1, `VTER_A_SEPC, 32'h5678);
    op(3'h4, 4'h0);
    chk(32'({curVirt, curPriv}), 32'h5);
    chk(redirPc, 32'h5678);
    apb(1'b0, `VTER_A_HSTAT, 32'h0);
    chk(q, 32'h0);
    op(3'h4, 4'h0);
    chk(32'({curVirt, curPriv}), 32'h4);
    apb(1'b0, `VTER_A_SSTAT, 32'h0);
    chk(q, 32'h2);
    $display("return test done");
    resetDut();
    apb(1'b1, `VTER_A_MSTAT, 32'h14);
    op(3'h3, 4'h0);
    apb(1'b1, `VTER_A_IMASK, 32'h8);
    op(3'h5, 4'h0);
    waitFor(1'b0);
    apb(1'b0, `VTER_A_MCAUSE, 32'h0);
    chk(q, 32'h2);
    chk(32'(irq), 32'h1);
    apb(1'b0, `VTER_A_ISTAT, 32'h0);
    chk(q & 32'h8, 32'h8);
    apb(1'b1, `VTER_A_ISTAT, 32'h8);
    @(posedge ref_clk);
    chk(32'(irq), 32'h0);
    $display("wait timeout test done");
    resetDut();
    op(3'h5, 4'h0);
    i_vter_pipe_model.setWake(1'b1);
    waitFor(1'b1);
    chk(32'(wfiBusy), 32'h0);
    i_vter_pipe_model.setWake(1'b0);
    apb(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h0);
    chk(32'(err), 32'h1);
    $display("wake and bus error test done");
    print_verdict();
  end
endmodule
